//--- shared/sbc_defines.vh
// Constants for the system bus and clock configuration registers.
// Assumes inclusion by bare name from the design files.
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// Register addresses on the 24-bit CPU data space
`define SBC_ADDR_BUS_CE 24'h00ff00
`define SBC_ADDR_WAIT_CLK 24'h00ff01
`define SBC_ADDR_PRESCALE 24'h00ff10
`define SBC_ADDR_SRC_SEL 24'h00ff12

// Field positions, bus and chip-enable register
`define SBC_BUS_MODE_HI 7
`define SBC_BUS_MODE_LO 6
`define SBC_CE_SIZE_HI 5
`define SBC_CE_SIZE_LO 4
`define SBC_CE_EN_HI 2
`define SBC_CE_EN_LO 0

// Field positions, wait, clock and voltage register
`define SBC_WAIT_HI 5
`define SBC_WAIT_LO 4
`define SBC_CPU_CLK_SEL 3
`define SBC_FAST_OSC_ON 2
`define SBC_LEVEL_HI 1
`define SBC_LEVEL_LO 0

// Field positions, timer prescaler register
`define SBC_T1_GATE 7
`define SBC_T1_RATIO_HI 6
`define SBC_T1_RATIO_LO 4
`define SBC_T0_GATE 3
`define SBC_T0_RATIO_HI 2
`define SBC_T0_RATIO_LO 0

// Field positions, prescaler source register
`define SBC_T1_SRC 1
`define SBC_T0_SRC 0

// Reset values
`define SBC_BUS_MODE_OPT 2'h1
`define SBC_CE_SIZE_RST 2'h3
`define SBC_CE_EN_RST 3'h7
`define SBC_WAIT_RST 2'h0
`define SBC_CPU_CLK_RST 1'h0
`define SBC_FAST_OSC_RST 1'h0
`define SBC_LEVEL_RST 2'h0
`define SBC_GATE_RST 1'h0
`define SBC_RATIO_RST 3'h0
`define SBC_SRC_RST 1'h0

// Bus mode encodings
`define SBC_BUS_4M_MAX 2'h3
`define SBC_BUS_4M_MIN 2'h2
`define SBC_BUS_64K 2'h1
`define SBC_BUS_OPTION 2'h0

`endif

//--- src/sbc_prescaler.v
// One timer prescaler channel: gated, selectable-source clock divider.
// Assumes both oscillator ticks are one-cycle enables on core_clk.
`timescale 1ns/1ps
`default_nettype none

module sbc_prescaler
(
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Oscillator ticks
  input wire fast_osc_tick,
  input wire slow_osc_tick,
  // Settings
  input wire clock_gate,
  input wire source_select,
  input wire [2:0] ratio,
  // Divided tick to the timer
  output reg timer_tick
);

  // Terminal count, divisor minus one, per source and ratio code
  function [11:0] ratio_last;
    input src_slow;
    input [2:0] code;
    begin
      if (src_slow)
      begin
        ratio_last = (12'h001 << code) - 12'h001;
      end
      else
      begin
        case (code)
          3'h7: ratio_last = 12'hfff;
          3'h6: ratio_last = 12'h3ff;
          3'h5: ratio_last = 12'h0ff;
          3'h4: ratio_last = 12'h07f;
          3'h3: ratio_last = 12'h03f;
          3'h2: ratio_last = 12'h01f;
          3'h1: ratio_last = 12'h007;
          default: ratio_last = 12'h001;
        endcase
      end
    end
  endfunction

  wire src_tick; // Tick of the chosen source
  wire [11:0] last; // Current terminal count
  reg [11:0] div_cnt; // Source ticks seen

  assign src_tick = source_select ? slow_osc_tick : fast_osc_tick;
  assign last = ratio_last(source_select, ratio);

  // Divider; held cleared while gated off so restart is clean
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt <= 12'h000;
      timer_tick <= 1'b0;
    end
    else if (!clock_gate)
    begin
      // Blocked clock
      div_cnt <= 12'h000;
      timer_tick <= 1'b0;
    end
    else if (src_tick)
    begin
      // Count; ratio change mid-count takes effect at next compare
      if (div_cnt >= last)
      begin
        div_cnt <= 12'h000;
        timer_tick <= 1'b1;
      end
      else
      begin
        div_cnt <= div_cnt + 12'h001;
        timer_tick <= 1'b0;
      end
    end
    else
    begin
      timer_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- src/sbc_sysconf.v
// System configuration registers: bus mode, chip enables, wait states,
// CPU clock, oscillator, supply level and timer prescalers.
// Assumes a synchronous CPU data port on core_clk and oscillator ticks
// already on core_clk as one-cycle enables.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.vh"

module sbc_sysconf
#(
  parameter [1:0] BUS_MODE_OPTION = `SBC_BUS_MODE_OPT
)
(
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // CPU data port
  input wire [23:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  // Interrupt hold
  output wire int_mask_hold,
  // Bus configuration
  output wire [1:0] bus_mode,
  output wire [1:0] enable_size_mode,
  output wire [2:0] select_lines_used,
  // Chip-enable and port sharing on three pins
  input wire [2:0] select_line_n,
  input wire [2:0] port_bit,
  output wire [2:0] shared_pin,
  // External access wait
  input wire ext_access_start,
  output wire bus_wait,
  // Clock and supply
  output wire cpu_clock_select,
  output wire fast_oscillator,
  output wire [1:0] supply_level,
  // Prescaler
  input wire fast_osc_tick,
  input wire slow_osc_tick,
  output wire timer0_tick,
  output wire timer1_tick
);

  // Field storage
  reg [1:0] bus_mode_fld; // Bus mode as written
  reg [1:0] ce_size; // Chip-enable size mode
  reg [2:0] ce_en; // Per-line chip-enable routing
  reg [1:0] wait_count; // Wait states for external access
  reg clk_sel; // CPU clock source
  reg osc_on; // Fast oscillator run
  reg [1:0] level; // Supply level code
  reg t1_gate; // Timer 1 clock gate
  reg [2:0] t1_ratio; // Timer 1 ratio
  reg t0_gate; // Timer 0 clock gate
  reg [2:0] t0_ratio; // Timer 0 ratio
  reg timer1_source_select; // Timer 1 source, high is slow
  reg timer0_source_select; // Timer 0 source, high is slow
  reg wrote_bus; // Bus register written since reset
  reg wrote_clk; // Clock register written since reset
  reg [1:0] wait_left; // Wait cycles still to insert

  // Decodes
  wire hit_bus; // Address match, bus register
  wire hit_clk; // Address match, clock register
  wire hit_pre; // Address match, prescaler register
  wire hit_src; // Address match, source select register
  wire [1:0] eff_mode; // Mode after option substitution
  reg [7:0] next_rdata; // Read mux

  assign hit_bus = (cpu_addr == `SBC_ADDR_BUS_CE);
  assign hit_clk = (cpu_addr == `SBC_ADDR_WAIT_CLK);
  assign hit_pre = (cpu_addr == `SBC_ADDR_PRESCALE);
  // Source select sits two bytes above the prescaler register
  assign hit_src = (cpu_addr == `SBC_ADDR_SRC_SEL);

  // Register writes; unused bit positions are simply never stored
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_mode_fld <= BUS_MODE_OPTION;
      ce_size <= `SBC_CE_SIZE_RST;
      ce_en <= `SBC_CE_EN_RST;
      wait_count <= `SBC_WAIT_RST;
      clk_sel <= `SBC_CPU_CLK_RST;
      osc_on <= `SBC_FAST_OSC_RST;
      level <= `SBC_LEVEL_RST;
      t1_gate <= `SBC_GATE_RST;
      t1_ratio <= `SBC_RATIO_RST;
      t0_gate <= `SBC_GATE_RST;
      t0_ratio <= `SBC_RATIO_RST;
      timer1_source_select <= `SBC_SRC_RST;
      timer0_source_select <= `SBC_SRC_RST;
    end
    else if (cpu_wr)
    begin
      if (hit_bus)
      begin
        // Bit 3 discarded
        bus_mode_fld <= cpu_wdata[`SBC_BUS_MODE_HI:`SBC_BUS_MODE_LO];
        ce_size <= cpu_wdata[`SBC_CE_SIZE_HI:`SBC_CE_SIZE_LO];
        ce_en <= cpu_wdata[`SBC_CE_EN_HI:`SBC_CE_EN_LO];
      end
      if (hit_clk)
      begin
        // Bits 7 and 6 discarded
        wait_count <= cpu_wdata[`SBC_WAIT_HI:`SBC_WAIT_LO];
        clk_sel <= cpu_wdata[`SBC_CPU_CLK_SEL];
        osc_on <= cpu_wdata[`SBC_FAST_OSC_ON];
        level <= cpu_wdata[`SBC_LEVEL_HI:`SBC_LEVEL_LO];
      end
      if (hit_pre)
      begin
        t1_gate <= cpu_wdata[`SBC_T1_GATE];
        t1_ratio <= cpu_wdata[`SBC_T1_RATIO_HI:`SBC_T1_RATIO_LO];
        t0_gate <= cpu_wdata[`SBC_T0_GATE];
        t0_ratio <= cpu_wdata[`SBC_T0_RATIO_HI:`SBC_T0_RATIO_LO];
      end
      if (hit_src)
      begin
        timer1_source_select <= cpu_wdata[`SBC_T1_SRC];
        timer0_source_select <= cpu_wdata[`SBC_T0_SRC];
      end
    end
  end

  // Write-seen flags; they only ever set, reset alone clears them
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrote_bus <= 1'b0;
      wrote_clk <= 1'b0;
    end
    else
    begin
      if (cpu_wr && hit_bus)
      begin
        wrote_bus <= 1'b1;
      end
      if (cpu_wr && hit_clk)
      begin
        wrote_clk <= 1'b1;
      end
    end
  end

  // Hold covers NMI too; the interrupt unit must honour it
  assign int_mask_hold = ~(wrote_bus & wrote_clk);

  // Read mux; gaps and unmapped addresses read zero
  always @*
  begin
    next_rdata = 8'h00;
    if (hit_bus)
    begin
      next_rdata = {bus_mode_fld, ce_size, 1'b0, ce_en};
    end
    else if (hit_clk)
    begin
      next_rdata = {2'h0, wait_count, clk_sel, osc_on, level};
    end
    else if (hit_pre)
    begin
      next_rdata = {t1_gate, t1_ratio, t0_gate, t0_ratio};
    end
    else if (hit_src)
    begin
      next_rdata = {6'h00, timer1_source_select, timer0_source_select};
    end
  end

  // Read data registered, valid the cycle after cpu_rd
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_rdata <= 8'h00;
    end
    else if (cpu_rd)
    begin
      cpu_rdata <= next_rdata;
    end
  end

  // Field 00 means the option default takes effect
  assign eff_mode = (bus_mode_fld == `SBC_BUS_OPTION) ?
                    BUS_MODE_OPTION : bus_mode_fld;
  assign bus_mode = eff_mode;
  assign enable_size_mode = ce_size;

  // Lines the size mode uses; outside 64K mode none are decoded here
  assign select_lines_used =
    (eff_mode != `SBC_BUS_64K) ? 3'h0 :
    (ce_size == 2'h3) ? 3'h1 :
    (ce_size == 2'h2) ? 3'h3 : 3'h7;

  // Shared pins: chip enable when routed, else plain port bit
  assign shared_pin = (ce_en & select_line_n) |
                      (~ce_en & port_bit);

  // Wait inserter; a new start restarts the count
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_left <= 2'h0;
    end
    else if (ext_access_start)
    begin
      wait_left <= wait_count;
    end
    else if (wait_left != 2'h0)
    begin
      wait_left <= wait_left - 2'h1;
    end
  end

  // Wait seen by the CPU while cycles remain
  assign bus_wait = (wait_left != 2'h0);

  // Clock and supply controls
  assign cpu_clock_select = clk_sel;
  assign fast_oscillator = osc_on;
  assign supply_level = level;

  // Timer 0 prescaler channel
  sbc_prescaler u_pre0
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .fast_osc_tick(fast_osc_tick),
    .slow_osc_tick(slow_osc_tick),
    .clock_gate(t0_gate),
    .source_select(timer0_source_select),
    .ratio(t0_ratio),
    .timer_tick(timer0_tick)
  );

  // Timer 1 prescaler channel
  sbc_prescaler u_pre1
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .fast_osc_tick(fast_osc_tick),
    .slow_osc_tick(slow_osc_tick),
    .clock_gate(t1_gate),
    .source_select(timer1_source_select),
    .ratio(t1_ratio),
    .timer_tick(timer1_tick)
  );

endmodule
`default_nettype wire

//--- verif/sbc_sysconf_props.sv
// Port checker for the system configuration block.
// Assumes it is bound into sbc_sysconf on one clock.
`timescale 1ns/1ps
`default_nettype none
module sbc_props
(
  // Clock, reset and CPU port
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_rdata,
  // Configuration outputs
  input wire logic int_mask_hold,
  input wire logic [1:0] bus_mode,
  input wire logic [1:0] enable_size_mode,
  input wire logic [2:0] select_lines_used,
  // Pins, wait and ticks
  input wire logic [2:0] select_line_n,
  input wire logic [2:0] port_bit,
  input wire logic [2:0] shared_pin,
  input wire logic ext_access_start,
  input wire logic bus_wait,
  input wire logic fast_osc_tick,
  input wire logic slow_osc_tick,
  input wire logic timer0_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Mask may only lift after a config write
  property p_int_fall;
    $fell(int_mask_hold) |-> $past(cpu_wr) &&
      ($past(cpu_addr) inside {24'h00ff00, 24'h00ff01});
  endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("mask lifted without config write");
  // Nothing but reset masks again
  property p_int_rise;
    !$rose(int_mask_hold);
  endproperty
  a_int_rise: assert property (p_int_rise)
    else $error("mask returned without reset");
  // Zero code is replaced by the option
  property p_mode;
    bus_mode != 2'h0;
  endproperty
  a_mode: assert property (p_mode)
    else $error("raw option code on bus mode");
  // Lines used follow size, only in 64K
  property p_lines;
    select_lines_used == ((bus_mode != 2'h1) ? 3'h0 :
      (enable_size_mode == 2'h3) ? 3'h1 :
      (enable_size_mode == 2'h2) ? 3'h3 : 3'h7);
  endproperty
  a_lines: assert property (p_lines)
    else $error("wrong select lines");
  // Pin matches both sources on bits where they agree
  property p_pin;
    ((shared_pin ^ select_line_n) & ~(select_line_n ^ port_bit)) == 3'h0;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin matches neither source");
  // Unmapped space reads as zero
  property p_unmapped;
    cpu_rd && cpu_addr == 24'h00ff03 |=> cpu_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  // Wait lasts three cycles at most
  property p_wait_len;
    ext_access_start ##1 !ext_access_start [*3] |=> !bus_wait;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("wait too long");
  // Wait only starts from an access
  property p_wait_src;
    $rose(bus_wait) |-> $past(ext_access_start);
  endproperty
  a_wait_src: assert property (p_wait_src)
    else $error("wait without access");
  // A timer tick needs a source tick
  property p_tick;
    timer0_tick |-> $past(fast_osc_tick) || $past(slow_osc_tick);
  endproperty
  a_tick: assert property (p_tick)
    else $error("timer tick without source");
endmodule
bind sbc_sysconf sbc_props sbc_props_inst (.core_clk, .sys_rst,
  .cpu_addr, .cpu_wr, .cpu_rd, .cpu_rdata, .int_mask_hold, .bus_mode,
  .enable_size_mode, .select_lines_used, .select_line_n, .port_bit,
  .shared_pin, .ext_access_start, .bus_wait, .fast_osc_tick,
  .slow_osc_tick, .timer0_tick);
`default_nettype wire

//--- verif/sbc_sysconf_tb.sv
// Self-checking bench for sbc_sysconf.
// Assumes the design and its bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module sbc_sysconf_tb;
  // Stimulus, driven at the falling edge
  logic core_clk = 0;
  logic sys_rst = 1;
  logic [23:0] cpu_addr = 24'h0;
  logic cpu_wr = 0;
  logic cpu_rd = 0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [2:0] select_line_n = 3'h0;
  logic [2:0] port_bit = 3'h7;
  logic ext_access_start = 0;
  logic src_tick = 0; // Feeds both oscillator inputs
  // Observed outputs
  wire [7:0] cpu_rdata;
  wire int_mask_hold, bus_wait, cpu_clock_select, fast_oscillator;
  wire [1:0] bus_mode, enable_size_mode, supply_level;
  wire [2:0] select_lines_used, shared_pin;
  wire timer0_tick, timer1_tick;
  // Bookkeeping
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n0 = 0;
  int n1 = 0;
  int b0, b1; // Tick counts at the start of a window
  int i, k;
  int fd [8] = '{2, 8, 32, 64, 128, 256, 1024, 4096}; // Fast divisors
  logic [1:0] m, s, em, w;
  logic [2:0] c;
  logic [7:0] v;
  sbc_sysconf sbc_sysconf_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .int_mask_hold(int_mask_hold), .bus_mode(bus_mode),
    .enable_size_mode(enable_size_mode),
    .select_lines_used(select_lines_used), .select_line_n(select_line_n),
    .port_bit(port_bit), .shared_pin(shared_pin),
    .ext_access_start(ext_access_start), .bus_wait(bus_wait),
    .cpu_clock_select(cpu_clock_select),
    .fast_oscillator(fast_oscillator), .supply_level(supply_level),
    .fast_osc_tick(src_tick), .slow_osc_tick(src_tick),
    .timer0_tick(timer0_tick), .timer1_tick(timer1_tick));
  // 25 MHz clock
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Single compare, wide enough for tick counts
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task wr(input logic [23:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1;
    @(negedge core_clk);
    cpu_wr = 0;
  endtask
  // One-cycle read, data taken after the strobe edge
  task rdc(input logic [23:0] a, input logic [7:0] e);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_rd = 1;
    @(negedge core_clk);
    cpu_rd = 0;
    chk(cpu_rdata, e);
  endtask
  // Tick counters and hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    n0 <= n0 + timer0_tick;
    n1 <= n1 + timer1_tick;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim;
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(negedge core_clk);
    sys_rst = 0;
    chk(int_mask_hold, 1);
    chk(select_lines_used, 3'h1);
    rdc(24'h00ff00, 8'h77);
    rdc(24'h00ff01, 8'h00);
    rdc(24'h00ff10, 8'h00);
    rdc(24'h00ff12, 8'h00);
    // Mask needs both registers written
    wr(24'h00ff01, 8'hff);
    chk(int_mask_hold, 1);
    wr(24'h00ff00, 8'hff);
    chk(int_mask_hold, 0);
    rdc(24'h00ff00, 8'hf7);
    // Every bus mode against every size code
    for (i = 0; i < 16; i++)
    begin
      m = i[3:2];
      s = i[1:0];
      wr(24'h00ff00, {m, s, 4'h7});
      em = (m == 2'h0) ? 2'h1 : m;
      chk(bus_mode, em);
      chk(enable_size_mode, s);
      chk(select_lines_used, (em != 2'h1) ? 3'h0 : (s == 2'h3) ? 3'h1 :
        (s == 2'h2) ? 3'h3 : 3'h7);
    end
    // Mixed routing on the shared pins
    wr(24'h00ff00, 8'h75);
    chk(shared_pin, 3'h2);
    wr(24'h00ff00, 8'h72);
    chk(shared_pin, 3'h5);
    // Sources differing on bits 0 and 2, line 1 routed
    select_line_n = 3'h6;
    port_bit = 3'h3;
    @(negedge core_clk);
    chk(shared_pin, 3'h3);
    // Wait counts, clock, oscillator and level
    for (i = 0; i < 4; i++)
    begin
      w = i[1:0];
      wr(24'h00ff01, {2'h3, w, w, w});
      rdc(24'h00ff01, {2'h0, w, w, w});
      chk(cpu_clock_select, w[1]);
      chk(fast_oscillator, w[0]);
      chk(supply_level, w);
      ext_access_start = 1;
      @(negedge core_clk);
      ext_access_start = 0;
      k = 0;
      repeat (6)
      begin
        k += bus_wait;
        @(negedge core_clk);
      end
      chk(k, w);
    end
    // Unmapped place ignores writes
    wr(24'h00ff03, 8'haa);
    rdc(24'h00ff03, 8'h00);
    // Timer 0 on slow source, timer 1 on fast
    wr(24'h00ff12, 8'hfd);
    rdc(24'h00ff12, 8'h01);
    for (i = 0; i < 9; i++)
    begin
      c = i[2:0];
      v = (i == 8) ? 8'h11 : {1'b1, c, 1'b1, c};
      wr(24'h00ff10, v);
      rdc(24'h00ff10, v);
      b0 = n0;
      b1 = n1;
      repeat (64)
      begin
        @(negedge core_clk);
        src_tick = 1;
        @(negedge core_clk);
        src_tick = 0;
      end
      repeat (3) @(negedge core_clk);
      chk(n0 - b0, (i == 8) ? 0 : 64 >> c);
      chk(n1 - b1, (i == 8) ? 0 : 64 / fd[c]);
      wr(24'h00ff10, 8'h00);
    end
    end_sim;
  end
endmodule
`default_nettype wire
